/* File: wdit_top.sv */
// watchdog / interval timer top with apb register slave
//
// Functional notes
// - watchdog or interval timer, chosen by mode
// - three-bit select picks overflow period
// - mode register write-only, reads return zero
// - reset clears mode register, counter stopped
// - each run write clears counter above the low nine stages, restarts
// - run bit cannot be cleared by software
// - interval mode: maskable interrupt each overflow
// - watchdog, action zero: non-maskable interrupt
// - watchdog, action one: reset, low pin
// - mode bits sticky once set
// - interval counting starts on run write
// - first overflow may come early by 2^9
// - run bit sits at bit seven
// - action bit three, select bit four
// - counter keeps running during halt
`timescale 1ns/1ps
`default_nettype none
module wdit_top #(
  parameter int SUB_DIV = wdit_pkg::SUB_DIV_DEF,
  parameter int PULSE_LEN = wdit_pkg::PULSE_CYC
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_mode,
  output logic mi_req,
  output logic nmi_req,
  output logic sys_rst_req,
  output logic overflow_out_n,
  output logic irq
);
  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [2:0] ots_r; // overflow time select code
  logic [2:0] ots_nxt;
  logic run_r; // run bit
  logic run_nxt;
  logic wdsel_r; // watchdog_select_bit
  logic wdsel_nxt;
  logic act_r; // overflow_action_bit
  logic act_nxt;
  logic [2:0] ist_r; // sticky interrupt status
  logic [2:0] ist_nxt;
  logic [2:0] imk_r; // interrupt enable mask
  logic [2:0] imk_nxt;
  logic [wdit_pkg::CNT_W-1:0] cnt_r; // prescaler chain of sub_clock
  logic [wdit_pkg::CNT_W-1:0] cnt_nxt;
  logic ovf_r; // one-cycle overflow
  logic ovf_nxt;
  logic mi_nxt;
  logic nmi_nxt;
  logic srst_nxt;
  logic irq_nxt;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;
  logic pready_nxt;
  logic tick; // sub_clock enable
  logic pin_n; // stretched pulse
  logic wr_acc; // write access phase
  logic rd_acc; // read access phase
  logic restart; // run bit written to one
  logic sel_bit; // tap of selected period
  logic sel_prev_r; // previous tap value
  logic sel_prev_nxt; // tap value to remember for the next cycle
  logic [4:0] tap; // stage index for selected period
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  wdit_subdiv #(.DIV(SUB_DIV)) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick)
  );
  wdit_pulse #(.LEN(PULSE_LEN)) u_pulse (
    .core_clk(core_clk),
    .rst(rst),
    .start(srst_nxt),
    .pin_n(pin_n)
  );
  // ----------------------------------------
  // apb decode, zero wait states
  // ----------------------------------------
  assign wr_acc = psel & penable & pwrite & pready;
  assign rd_acc = psel & penable & ~pwrite & pready;
  assign restart = wr_acc && (paddr == wdit_pkg::WMC_ADDR) && pstrb[0]
                   && pwdata[wdit_pkg::RUN_BIT];
  // a new code while counting drops any edge in flight
  // period tap per select code
  always_comb
  begin
    unique case (ots_r)
      3'h7: tap = 5'd20;
      default: tap = 5'(5'd12 + {2'b00, ots_r});
    endcase
  end
  assign sel_bit = cnt_r[tap];
  // ----------------------------------------
  // counter and overflow detect
  // ----------------------------------------
  // overflow is the falling edge of the selected stage; the low
  // nine stages survive a restart, so the first period may be short
  always_comb
  begin
    cnt_nxt = cnt_r;
    ovf_nxt = 1'b0;
    // remembered tap forced low on restart or new code: no fake edge
    sel_prev_nxt = (restart || (ots_nxt != ots_r)) ? 1'b0 : sel_bit;
    // low prescaler stages kept on restart
    if (restart)
      cnt_nxt = {{(wdit_pkg::CNT_W-wdit_pkg::LOW_STAGES){1'b0}}, cnt_r[wdit_pkg::LOW_STAGES-1:0]};
    else if (run_r && tick)
      cnt_nxt = cnt_r + 22'h000001;
    if (run_r && !restart && sel_prev_r && !sel_bit)
      ovf_nxt = 1'b1;
  end
  always_comb
  begin
    mi_nxt = ovf_r && !wdsel_r;
    nmi_nxt = ovf_r && wdsel_r && !act_r;
    srst_nxt = ovf_r && wdsel_r && act_r;
  end
  // ----------------------------------------
  // register next values
  // ----------------------------------------
  always_comb
  begin
    ots_nxt = ots_r;
    run_nxt = run_r;
    wdsel_nxt = wdsel_r;
    act_nxt = act_r;
    imk_nxt = imk_r;
    ist_nxt = ist_r;
    if (wr_acc)
    begin
      if (paddr == wdit_pkg::OTS_ADDR && pstrb[0])
        ots_nxt = pwdata[2:0];
      if (paddr == wdit_pkg::WMC_ADDR && pstrb[0])
      begin
        run_nxt = run_r | pwdata[wdit_pkg::RUN_BIT];
        wdsel_nxt = wdsel_r | pwdata[wdit_pkg::WDSEL_BIT];
        act_nxt = act_r | pwdata[wdit_pkg::ACT_BIT];
      end
      if (paddr == wdit_pkg::IMK_ADDR && pstrb[0])
        imk_nxt = pwdata[2:0];
      if (paddr == wdit_pkg::IST_ADDR && pstrb[0])
        ist_nxt = ist_r & ~pwdata[2:0];
    end
    // set wins over clear
    ist_nxt = ist_nxt | {srst_nxt, nmi_nxt, mi_nxt};
    irq_nxt = |(ist_nxt & imk_nxt);
  end
  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb
  begin
    prdata_nxt = 32'h00000000;
    pslverr_nxt = 1'b0;
    pready_nxt = psel & ~penable;
    if (psel && !penable)
    begin
      unique case (paddr)
        wdit_pkg::OTS_ADDR: prdata_nxt = {29'h0, ots_r};
        wdit_pkg::WMC_ADDR: prdata_nxt = 32'h00000000;
        wdit_pkg::IST_ADDR: prdata_nxt = {29'h0, ist_r};
        wdit_pkg::IMK_ADDR: prdata_nxt = {29'h0, imk_r};
        wdit_pkg::CST_ADDR: prdata_nxt = {7'h00, halt_mode, act_r, wdsel_r, run_r, 1'b0, cnt_r[21:2]};
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end
  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ots_r <= wdit_pkg::OTS_RST[2:0];
      run_r <= wdit_pkg::WMC_RST[wdit_pkg::RUN_BIT];
      wdsel_r <= wdit_pkg::WMC_RST[wdit_pkg::WDSEL_BIT];
      act_r <= wdit_pkg::WMC_RST[wdit_pkg::ACT_BIT];
      ist_r <= wdit_pkg::IRQ_RST;
      imk_r <= wdit_pkg::IRQ_RST;
      cnt_r <= '0;
      ovf_r <= 1'b0;
      sel_prev_r <= 1'b0;
      mi_req <= 1'b0;
      nmi_req <= 1'b0;
      sys_rst_req <= 1'b0;
      overflow_out_n <= 1'b1;
      irq <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      ots_r <= ots_nxt;
      run_r <= run_nxt;
      wdsel_r <= wdsel_nxt;
      act_r <= act_nxt;
      ist_r <= ist_nxt;
      imk_r <= imk_nxt;
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
      sel_prev_r <= sel_prev_nxt;
      mi_req <= mi_nxt;
      nmi_req <= nmi_nxt;
      sys_rst_req <= srst_nxt;
      overflow_out_n <= pin_n;
      irq <= irq_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_run_sticky: assert property (@(posedge core_clk) disable iff (rst) run_r |=> run_r)
    else $error("run bit cleared without reset");
  a_mode_sticky: assert property (@(posedge core_clk) disable iff (rst)
    (wdsel_r && act_r) |=> (wdsel_r && act_r))
    else $error("mode bits cleared without reset");
  a_stop_idle: assert property (@(posedge core_clk) disable iff (rst)
    !run_r |=> !ovf_r)
    else $error("overflow while stopped");
  a_mi_route: assert property (@(posedge core_clk) disable iff (rst)
    (ovf_r && !wdsel_r) |=> mi_req && !nmi_req && !sys_rst_req)
    else $error("interval overflow misrouted");
  a_nmi_route: assert property (@(posedge core_clk) disable iff (rst)
    (ovf_r && wdsel_r && !act_r) |=> nmi_req && !mi_req)
    else $error("nmi overflow misrouted");
  a_rst_pin: assert property (@(posedge core_clk) disable iff (rst)
    sys_rst_req |=> !overflow_out_n)
    else $error("pin not low after reset request");
  a_single_req: assert property (@(posedge core_clk) disable iff (rst)
    (mi_req || nmi_req || sys_rst_req) |=> !(mi_req || nmi_req || sys_rst_req))
    else $error("request longer than one cycle");
  a_wmc_read: assert property (@(posedge core_clk) disable iff (rst)
    (psel && !penable && !pwrite && paddr == wdit_pkg::WMC_ADDR) |=> prdata == 32'h00000000)
    else $error("mode register readable");
  a_restart_clr: assert property (@(posedge core_clk) disable iff (rst)
    restart |=> cnt_r[wdit_pkg::CNT_W-1:wdit_pkg::LOW_STAGES] == '0)
    else $error("restart did not clear counter");
  // ----------------------------------------
  // routing, counting and bus answer checks
  // ----------------------------------------
  // reset route takes the overflow alone
  a_rst_route: assert property (@(posedge core_clk) disable iff (rst)
    (ovf_r && wdsel_r && act_r) |=> sys_rst_req && !mi_req && !nmi_req)
    else $error("reset overflow misrouted");
  // never a maskable and another request together
  a_mode_excl: assert property (@(posedge core_clk) disable iff (rst)
    mi_req |-> !(nmi_req || sys_rst_req))
    else $error("interval and watchdog request together");
  // pin falls only after a reset request
  a_pin_cause: assert property (@(posedge core_clk) disable iff (rst)
    $fell(overflow_out_n) |-> $past(sys_rst_req))
    else $error("pin low without reset request");
  // stopped counter holds its value
  a_stop_count: assert property (@(posedge core_clk) disable iff (rst)
    !run_r |=> $stable(cnt_r))
    else $error("counter moved while stopped");
  // halt does not stop a running count
  a_halt_count: assert property (@(posedge core_clk) disable iff (rst)
    (run_r && tick && !restart && halt_mode) |=> cnt_r == $past(cnt_r) + 22'h000001)
    else $error("counter stalled during halt");
  // mode register answers zero when read data is taken
  a_wmc_rdata: assert property (@(posedge core_clk) disable iff (rst)
    (rd_acc && paddr == wdit_pkg::WMC_ADDR) |-> prdata == 32'h00000000)
    else $error("mode register contents returned");
  // every setup cycle is answered in the next cycle
  a_apb_answer: assert property (@(posedge core_clk) disable iff (rst)
    (psel && !penable) |=> pready)
    else $error("no ready after setup cycle");
endmodule // wdit_top
`default_nettype wire

/* File: wdit_pkg.sv */
// package: register map, field positions, reset values and timing constants for the watchdog/interval timer
package wdit_pkg;
  // ----------------------------------------
  // register byte addresses on apb
  // ----------------------------------------
  localparam logic [15:0] OTS_ADDR = 16'hFF42; // overflow time select
  localparam logic [15:0] WMC_ADDR = 16'hFF44; // mode control, write only
  localparam logic [15:0] IST_ADDR = 16'hFF48; // interrupt status, write one to clear
  localparam logic [15:0] IMK_ADDR = 16'hFF4C; // interrupt mask
  localparam logic [15:0] CST_ADDR = 16'hFF50; // counter state readback
  // ----------------------------------------
  // mode register field positions
  // ----------------------------------------
  localparam int RUN_BIT = 7; // run bit
  localparam int WDSEL_BIT = 4; // watchdog_select_bit
  localparam int ACT_BIT = 3; // overflow_action_bit
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] OTS_RST = 8'h00;
  localparam logic [7:0] WMC_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // ----------------------------------------
  // interrupt status bit positions
  // ----------------------------------------
  localparam int IRQ_MI = 0; // maskable interval interrupt
  localparam int IRQ_NMI = 1; // non-maskable interrupt
  localparam int IRQ_RST_EV = 2; // watchdog reset event
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CORE_MHZ = 200; // core clock rate
  localparam int SUB_DIV_DEF = 6104; // core cycles per sub_clock tick (~32.768 kHz)
  localparam int LOW_STAGES = 9; // prescaler stages not cleared on restart
  localparam int PULSE_US = 20; // overflow_out_n low time in us
  localparam int PULSE_CYC = PULSE_US * CORE_MHZ; // 4000 core cycles
  localparam int CNT_W = 22; // sub_clock stage count
endpackage

/* File: wdit_subdiv.sv */
// sub_clock tick generator: one-cycle enable pulse every div core cycles
`timescale 1ns/1ps
`default_nettype none
module wdit_subdiv #(
  parameter int DIV = wdit_pkg::SUB_DIV_DEF
)(
  input wire logic core_clk,
  input wire logic rst,
  output logic tick
);
  // ----------------------------------------
  // divider counter
  // ----------------------------------------
  logic [15:0] cnt_r; // cycles since last tick
  logic [15:0] cnt_nxt;
  logic tick_nxt;
  // next state of divider
  always_comb
  begin
    tick_nxt = (cnt_r == 16'(DIV - 1));
    cnt_nxt = tick_nxt ? 16'h0000 : cnt_r + 16'h0001;
  end
  // register divider
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule // wdit_subdiv
`default_nettype wire

/* File: wdit_pulse.sv */
// low pulse stretcher for the overflow output pin
`timescale 1ns/1ps
`default_nettype none
module wdit_pulse #(
  parameter int LEN = wdit_pkg::PULSE_CYC
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  output logic pin_n
);
  // ----------------------------------------
  // pulse length counter
  // ----------------------------------------
  logic [15:0] cnt_r; // remaining low cycles
  logic [15:0] cnt_nxt;
  // next count: load on start, else count down
  always_comb
  begin
    if (start)
      cnt_nxt = 16'(LEN);
    else if (cnt_r != 16'h0000)
      cnt_nxt = cnt_r - 16'h0001;
    else
      cnt_nxt = cnt_r;
  end
  // register count and pin
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 16'h0000;
      pin_n <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      pin_n <= (cnt_nxt == 16'h0000);
    end
  end
endmodule // wdit_pulse
`default_nettype wire

/* File: wdit_top_tb.sv */
// self-checking testbench for the watchdog / interval timer
`timescale 1ns/1ps
`default_nettype none
module wdit_top_tb;
  // ----------------------------------------
  // signals and counters
  // ----------------------------------------
  logic core_clk = 1'b0; // 200 MHz core clock
  logic rst = 1'b1; // async reset, high
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, err, halt_mode = 1'b0;
  logic mi_req, nmi_req, sys_rst_req, overflow_out_n, irq;
  logic [31:0] seed = 32'h919FB72D; // xorshift state
  int n_mismatch = 0, num_checks = 0, t, n;
  localparam int P = 16384; // code 0: 2^13 ticks of 2 cycles

  // clock, half period 2.5 ns
  always #2.5 core_clk = ~core_clk;

  // short sub clock divide and pin pulse keep the run brief
  wdit_top #(.SUB_DIV(2), .PULSE_LEN(8)) u_wdit_top (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode), .mi_req(mi_req), .nmi_req(nmi_req),
    .sys_rst_req(sys_rst_req), .overflow_out_n(overflow_out_n), .irq(irq));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // next random word
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // compare and count
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    num_checks++;
    if (sn !== ex)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer, result in rd and err
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      chk("pready wait", 1, 0);
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait for a request pulse {reset, nmi, maskable}; cyc = edges waited
  task automatic wait_req(input logic [2:0] ex, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge core_clk);
      cyc++;
    end
    while ({sys_rst_req, nmi_req, mi_req} === 3'b000 && cyc < P + 200);
    chk("request kind", ex, {sys_rst_req, nmi_req, mi_req});
    if (cyc >= P + 200)
      give_verdict();
    @(posedge core_clk);
    chk("pulse width", 0, {sys_rst_req, nmi_req, mi_req});
  endtask

  // hold reset six cycles
  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    do_reset();
    apb(1'b0, wdit_pkg::OTS_ADDR, 0);
    chk("ots reset", {24'h0, wdit_pkg::OTS_RST}, rd);
    apb(1'b0, wdit_pkg::WMC_ADDR, 0);
    chk("mode read", 0, rd);
    apb(1'b0, wdit_pkg::CST_ADDR, 0);
    chk("mode bits reset", 0, rd[23:21]);
    t = rd[19:0];
    repeat (40) @(posedge core_clk);
    apb(1'b0, wdit_pkg::CST_ADDR, 0);
    chk("stopped count", t, rd[19:0]);
    apb(1'b0, 16'hFF60, 0);
    chk("unmapped error", 1, err);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      halt_mode <= seed[9];
      apb(1'b1, wdit_pkg::OTS_ADDR, {seed[31:8], 5'h00, i[2:0]});
      apb(1'b0, wdit_pkg::OTS_ADDR, 0);
      chk("ots code", {29'h0, i[2:0]}, rd);
    end
    // strobe of byte 0 low: write ignored
    pstrb <= 4'hE;
    apb(1'b1, wdit_pkg::OTS_ADDR, 32'h0000_0003);
    pstrb <= 4'hF;
    apb(1'b0, wdit_pkg::OTS_ADDR, 0);
    chk("ots strobe", 32'h0000_0007, rd);
    halt_mode <= 1'b1;
    apb(1'b1, wdit_pkg::OTS_ADDR, 0);
    apb(1'b1, wdit_pkg::IMK_ADDR, 32'h0000_0001);
    apb(1'b1, wdit_pkg::WMC_ADDR, 32'h0000_0088);
    wait_req(3'b001, t);
    chk("first interval", 1, t >= P - 1028 && t <= P + 4);
    wait_req(3'b001, t);
    chk("period", P, t + 1);
    chk("irq raised", 1, irq);
    // mask, unmask, then clear
    apb(1'b1, wdit_pkg::IMK_ADDR, 0);
    @(posedge core_clk);
    chk("irq masked", 0, irq);
    apb(1'b1, wdit_pkg::IMK_ADDR, 32'h0000_0001);
    @(posedge core_clk);
    chk("irq unmasked", 1, irq);
    apb(1'b1, wdit_pkg::IST_ADDR, 32'h0000_0001);
    apb(1'b0, wdit_pkg::IST_ADDR, 0);
    chk("status cleared", 0, rd[0]);
    chk("irq cleared", 0, irq);
    seed = xs(seed);
    apb(1'b1, wdit_pkg::WMC_ADDR, {seed[31:8], 8'h00});
    apb(1'b0, wdit_pkg::CST_ADDR, 0);
    chk("mode bits kept", 3'b101, rd[23:21]);
    repeat (8000) @(posedge core_clk);
    apb(1'b1, wdit_pkg::WMC_ADDR, 32'h0000_0080);
    wait_req(3'b001, t);
    chk("restart interval", 1, t >= P - 1028 && t <= P + 4);
    do_reset();
    apb(1'b1, wdit_pkg::WMC_ADDR, 32'h0000_0090);
    apb(1'b1, wdit_pkg::WMC_ADDR, 0);
    apb(1'b0, wdit_pkg::CST_ADDR, 0);
    chk("sticky select", 3'b011, rd[23:21]);
    wait_req(3'b010, t);
    do_reset();
    apb(1'b1, wdit_pkg::WMC_ADDR, 32'h0000_0098);
    wait_req(3'b100, t);
    n = 0;
    repeat (20)
    begin
      if (overflow_out_n === 1'b0)
        n++;
      @(posedge core_clk);
    end
    chk("pin low cycles", 8, n);
    chk("pin idle", 1, overflow_out_n);
    give_verdict();
  end
endmodule // wdit_top_tb
`default_nettype wire
